// ===== scp_config_port.sv
`timescale 1ns/100ps
`default_nettype none
module scp_config_port (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic reset_pin_n_i,
  input wire scp_pkg::scp_serial_t serial_i,
  input wire logic sleep_request_n_i,
  input wire logic cp_event_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic serial_readback_out_pin_o,
  output logic serial_readback_out_pin_oe_o,
  output logic sync_o,
  output scp_pkg::scp_pwr_t pwr_o,
  output scp_pkg::scp_outcfg_t [5:0] out_cfg_o
);
  import scp_pkg::*;

  typedef struct packed {
    scp_state_t st;
    logic dph;
    logic sclk_q;
    logic cs_q;
    logic [3:0] bitcnt;
    logic [15:0] sr;
    logic rw;
    logic [1:0] len;
    logic [1:0] left;
    logic [9:0] addr;
    logic [7:0] rd_sr;
    logic [7:0] cfg;
    logic sdio;
    logic sdio_oe;
    logic so;
    logic so_oe;
    logic wr;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic upd;
    logic boot;
    logic sync;
  } scp_core_t;

  scp_core_t r_ff, nxt_r;
  logic rst_n;
  logic rise, fall, cs_fall;
  logic lsb, srst, last_bit;
  logic byte_end, instr_end;
  logic [15:0] sr_in;
  logic [7:0] rx_byte;
  logic [9:0] look_addr;
  logic [3:0] look_idx;
  logic [7:0] rd_byte;
  scp_regs_t bank_buf, bank_act;

  // shift one serial bit in, either bit order
  function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic b,
                                           input logic lsb_first);
    shift_in = lsb_first ? {b, sr[15:1]} : {sr[14:0], b};
  endfunction

  // next register address, up when lsb first, else down with a wrap from zero to the top
  function automatic logic [9:0] step_addr(input logic [9:0] a, input logic lsb_first);
    if (lsb_first) begin
      step_addr = a + 10'h001;
    end else if (a == ADDR_PORT_CFG) begin
      step_addr = ADDR_TOP;
    end else begin
      step_addr = a - 10'h001;
    end
  endfunction

  // address to buffered bank slot
  function automatic logic [3:0] reg_index(input logic [9:0] a);
    if (a == ADDR_READBACK) begin
      reg_index = IDX_RB;
    end else if (a == ADDR_PLL_CTRL) begin
      reg_index = IDX_PLL;
    end else if (a == ADDR_DIST) begin
      reg_index = IDX_DIST;
    end else if (a >= ADDR_OUT0 && a <= ADDR_OUT_LAST) begin
      reg_index = IDX_OUT0 + 4'(a - ADDR_OUT0);
    end else begin
      reg_index = IDX_NONE;
    end
  endfunction

  // power-on and reset pin both restore every reset value at once
  assign rst_n = nrst_i & reset_pin_n_i;

  // edge detection on the sampled serial pins
  assign rise = serial_i.sclk & ~r_ff.sclk_q;
  assign fall = ~serial_i.sclk & r_ff.sclk_q;
  assign cs_fall = ~serial_i.cs_n & r_ff.cs_q;
  assign lsb = r_ff.cfg[BIT_LSB];
  assign srst = r_ff.cfg[BIT_SRST_LO] | r_ff.cfg[BIT_SRST_HI];
  assign sr_in = shift_in(r_ff.sr, serial_i.sdio, lsb);
  assign rx_byte = lsb ? sr_in[15:8] : sr_in[7:0];
  assign last_bit = (r_ff.len == LEN_STREAM) ? (r_ff.addr == ADDR_TOP)
                                             : (r_ff.left == 2'h0);

  // final rise of an instruction word or a data byte while selected
  assign byte_end = (r_ff.st == ST_DATA) && rise && !serial_i.cs_n && (r_ff.bitcnt == BYTE_LAST);
  assign instr_end = (r_ff.st == ST_INSTR) && rise && !serial_i.cs_n
                     && (r_ff.bitcnt == INSTR_LAST);

  // address of the next byte to be read back
  assign look_addr = (r_ff.st == ST_INSTR) ? sr_in[9:0] : step_addr(r_ff.addr, lsb);
  assign look_idx = reg_index(look_addr);

  // readback source: port config, active or buffered bank
  always_comb begin
    if (look_addr == ADDR_PORT_CFG) begin
      rd_byte = r_ff.cfg;
    end else if (look_idx == IDX_NONE) begin
      rd_byte = 8'h00;
    end else if (bank_act[IDX_RB][BIT_RB_ACTIVE]) begin
      rd_byte = bank_act[look_idx];
    end else begin
      rd_byte = bank_buf[look_idx];
    end
  end

  // serial port state machine and control register
  always_comb begin
    nxt_r = r_ff;
    nxt_r.sclk_q = serial_i.sclk;
    nxt_r.cs_q = serial_i.cs_n;
    nxt_r.wr = 1'b0;
    nxt_r.upd = 1'b0;
    nxt_r.boot = 1'b0;
    nxt_r.sync = r_ff.boot | srst | bank_act[IDX_DIST][BIT_SOFT_SYNC];
    if (serial_i.cs_n) begin
      nxt_r.sdio_oe = 1'b0;
      nxt_r.so_oe = 1'b0;
    end
    case (r_ff.st)
      ST_IDLE: begin
        if (cs_fall) begin
          nxt_r.st = ST_INSTR;
          nxt_r.dph = 1'b0;
          nxt_r.bitcnt = 4'h0;
          nxt_r.sr = 16'h0000;
          nxt_r.sdio_oe = 1'b0;
          nxt_r.so_oe = 1'b0;
        end
      end
      ST_INSTR, ST_DATA: begin
        if (serial_i.cs_n) begin
          if (r_ff.bitcnt[2:0] != 3'h0) begin
            nxt_r.st = ST_IDLE;
          end else if (r_ff.st == ST_INSTR && r_ff.bitcnt == 4'h0) begin
            nxt_r.st = ST_IDLE;
          end else if (r_ff.st == ST_DATA && r_ff.len == LEN_STREAM) begin
            nxt_r.st = ST_IDLE;
          end else begin
            nxt_r.st = ST_STALL;
          end
        end else if (rise && r_ff.st == ST_INSTR) begin
          nxt_r.sr = sr_in;
          nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
          if (r_ff.bitcnt == INSTR_LAST) begin
            // long 16-bit instruction is the only format
            nxt_r.rw = sr_in[15];
            nxt_r.len = sr_in[14:13];
            nxt_r.left = sr_in[14:13];
            nxt_r.addr = sr_in[9:0];
            nxt_r.rd_sr = rd_byte;
            nxt_r.st = ST_DATA;
            nxt_r.dph = 1'b1;
            nxt_r.bitcnt = 4'h0;
            nxt_r.sr = 16'h0000;
          end
        end else if (rise) begin
          nxt_r.sr = sr_in;
          nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
          if (r_ff.bitcnt == BYTE_LAST) begin
            if (!r_ff.rw) begin
              if (r_ff.addr == ADDR_PORT_CFG) begin
                nxt_r.cfg = rx_byte;
              end else if (r_ff.addr == ADDR_UPDATE) begin
                nxt_r.upd = rx_byte[BIT_UPDATE];
              end else begin
                nxt_r.wr = 1'b1;
                nxt_r.wr_idx = reg_index(r_ff.addr);
                nxt_r.wr_data = rx_byte;
              end
            end
            nxt_r.bitcnt = 4'h0;
            nxt_r.sr = 16'h0000;
            if (last_bit) begin
              nxt_r.st = ST_IDLE;
            end else begin
              nxt_r.addr = step_addr(r_ff.addr, lsb);
              nxt_r.left = r_ff.left - 2'h1;
              nxt_r.rd_sr = rd_byte;
            end
          end
        end else if (fall && r_ff.st == ST_DATA && r_ff.rw) begin
          // launch the next readback bit on the chosen pin
          nxt_r.sdio = lsb ? r_ff.rd_sr[0] : r_ff.rd_sr[7];
          nxt_r.so = nxt_r.sdio;
          nxt_r.rd_sr = lsb ? {1'b0, r_ff.rd_sr[7:1]} : {r_ff.rd_sr[6:0], 1'b0};
          nxt_r.sdio_oe = ~r_ff.cfg[BIT_SDO_EN];
          nxt_r.so_oe = r_ff.cfg[BIT_SDO_EN];
        end
      end
      ST_STALL: begin
        if (cs_fall) begin
          nxt_r.st = r_ff.dph ? ST_DATA : ST_INSTR;
        end
      end
      default: nxt_r.st = ST_IDLE;
    endcase
  end

  // state register, defaults under either reset
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
      r_ff.cfg <= PORT_CFG_RST;
      r_ff.cs_q <= 1'b1;
      r_ff.boot <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  scp_reg_bank u_bank (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .wr_i(r_ff.wr),
    .wr_idx_i(r_ff.wr_idx),
    .wr_data_i(r_ff.wr_data),
    .update_i(r_ff.upd),
    .soft_rst_i(srst),
    .buf_o(bank_buf),
    .act_o(bank_act)
  );

  scp_power_ctl u_power (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .act_i(bank_act),
    .sleep_request_n_i(sleep_request_n_i),
    .cp_event_i(cp_event_i),
    .pwr_o(pwr_o),
    .out_cfg_o(out_cfg_o)
  );

  // pins straight from the state register
  assign sdio_o = r_ff.sdio;
  assign sdio_oe_o = r_ff.sdio_oe;
  assign serial_readback_out_pin_o = r_ff.so;
  assign serial_readback_out_pin_oe_o = r_ff.so_oe;
  assign sync_o = r_ff.sync;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n);
  a_float_deselect: assert property (
    serial_i.cs_n |=> !sdio_oe_o && !serial_readback_out_pin_oe_o)
    else $error("data pin driven while deselected");
  a_pin_select: assert property (
    (sdio_oe_o |-> !r_ff.cfg[BIT_SDO_EN])
      and (serial_readback_out_pin_oe_o |-> r_ff.cfg[BIT_SDO_EN]))
    else $error("readback on wrong pin");
  a_launch_falling: assert property (
    $changed(sdio_oe_o) && sdio_oe_o |-> $past(serial_i.sclk, 2) && !$past(serial_i.sclk))
    else $error("readback not launched on falling edge");
  a_midbyte_abandon: assert property (
    (r_ff.st == ST_INSTR || r_ff.st == ST_DATA) && serial_i.cs_n
      && r_ff.bitcnt[2:0] != 3'h0 |=> r_ff.st == ST_IDLE)
    else $error("mid-byte deselect not abandoned");
  a_fresh_instr: assert property (
    r_ff.st == ST_IDLE && cs_fall |=> r_ff.st == ST_INSTR && r_ff.bitcnt == 4'h0)
    else $error("new instruction not started clean");
  a_stall_resume: assert property (
    r_ff.st == ST_STALL && cs_fall |=> r_ff.st == ($past(r_ff.dph) ? ST_DATA : ST_INSTR))
    else $error("stall did not resume");
  a_stream_top_stop: assert property (
    r_ff.st == ST_DATA && !serial_i.cs_n && rise && r_ff.bitcnt == BYTE_LAST
      && r_ff.len == LEN_STREAM && r_ff.addr == ADDR_TOP |=> r_ff.st == ST_IDLE)
    else $error("stream did not stop at top address");
  a_soft_reset_sync: assert property (
    srst |=> sync_o ##1 bank_act == REG_DFLT)
    else $error("soft reset without defaults and sync");
  // framing, decode and address stepping
  a_launch_bits: assert property (
    $changed(sdio_o) || $changed(serial_readback_out_pin_o) |-> $past(fall))
    else $error("readback bit moved without falling edge");
  a_capture_rising: assert property (
    $changed(r_ff.cfg) |-> $past(rise))
    else $error("port config changed without rising edge");
  a_stall_wait: assert property (
    r_ff.st == ST_STALL && !cs_fall |=> r_ff.st == ST_STALL)
    else $error("stall left without select falling");
  a_instr_decode: assert property (
    instr_end |=> r_ff.st == ST_DATA && r_ff.bitcnt == 4'h0 && r_ff.rw == $past(sr_in[15])
      && r_ff.addr == $past(sr_in[9:0]))
    else $error("instruction not decoded after sixteen bits");
  a_len_decode: assert property (
    instr_end |=> r_ff.len == $past(sr_in[14:13]) && r_ff.left == r_ff.len)
    else $error("length field not taken");
  a_cfg_direct: assert property (
    byte_end && !r_ff.rw && r_ff.addr == ADDR_PORT_CFG |=> r_ff.cfg == $past(rx_byte))
    else $error("port config write not immediate");
  a_addr_step: assert property (
    byte_end && !last_bit |=> r_ff.addr == ($past(lsb) ? $past(r_ff.addr) + 10'h001
      : ($past(r_ff.addr) == ADDR_PORT_CFG ? ADDR_TOP : $past(r_ff.addr) - 10'h001)))
    else $error("address not stepped in bit order");
  a_update_pulse: assert property (
    byte_end && !r_ff.rw && r_ff.addr == ADDR_UPDATE && rx_byte[BIT_UPDATE]
      |=> r_ff.upd ##1 !r_ff.upd)
    else $error("update not a single pulse");
  c_stall: cover property (r_ff.st == ST_STALL ##[1:50] r_ff.st == ST_DATA);
  c_read: cover property (sdio_oe_o ##1 !sdio_oe_o);
  c_update: cover property (r_ff.upd);
  c_stream_end: cover property (r_ff.len == LEN_STREAM && r_ff.st == ST_DATA ##1 r_ff.st == ST_IDLE);
endmodule
`default_nettype wire

// ===== scp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// serial master standing in for the host controller
module scp_host_model (
  input wire logic mclk_i,
  input wire logic sdio_i,
  input wire logic sdio_oe_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output wire scp_pkg::scp_serial_t ser_o
);
  import scp_pkg::*;
  logic sclk;
  logic cs_n;
  logic drv_en;
  logic drv_bit;
  logic last_lvl;
  logic lsb;
  logic uni;
  logic [7:0] rb;
  logic lvl;
  logic pin;
  // idle bus: clock low, deselected, line released
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv_en = 1'b0;
    drv_bit = 1'b0;
    last_lvl = 1'b0;
    lsb = 1'b0;
    uni = 1'b0;
    rb = 8'h00;
  end
  // a released line shows the inverse of its last level
  assign lvl = drv_en ? drv_bit : (sdio_oe_i ? sdio_i : ~last_lvl);
  assign pin = uni ? (sdo_oe_i ? sdo_i : ~sdo_i) : lvl;
  assign ser_o = '{sclk: sclk, cs_n: cs_n, sdio: lvl};
  // remember the last driven level only
  always @(posedge mclk_i) begin
    if (drv_en || sdio_oe_i) begin
      last_lvl <= lvl;
    end
  end
  // waits n edges, then steps just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #10;
  endtask
  // data set while the clock is low, taken on the rise
  task automatic shift(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      drv_bit = lsb ? b[i] : b[7-i];
      tick(4);
      sclk = 1'b1;
      rb = lsb ? {pin, rb[7:1]} : {rb[6:0], pin};
      tick(4);
    end
  endtask
  task automatic put(input logic [7:0] b);
    drv_en = 1'b1;
    shift(b, 8);
  endtask
  task automatic get(output logic [7:0] v);
    drv_en = 1'b0;
    shift(8'h00, 8);
    v = rb;
  endtask
  // direction, length, address with top bits zero
  task automatic instr(input logic r, input logic [1:0] len, input logic [9:0] a);
    logic [15:0] w;
    w = {r, len, 3'b000, a};
    if (lsb) begin
      put(w[7:0]);
      put(w[15:8]);
    end else begin
      put(w[15:8]);
      put(w[7:0]);
    end
  endtask
  task automatic cs_dn;
    cs_n = 1'b0;
    tick(4);
  endtask
  // select rises with the clock parked low and the line released, mid-byte or not
  task automatic cs_up;
    sclk = 1'b0;
    drv_en = 1'b0;
    tick(4);
    cs_n = 1'b1;
    tick(4);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    cs_dn();
    instr(1'b0, 2'b00, a);
    put(v);
    cs_up();
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    cs_dn();
    instr(1'b1, 2'b00, a);
    get(v);
    cs_up();
  endtask
  task automatic upd;
    wr(ADDR_UPDATE, 8'h01);
  endtask
endmodule
`default_nettype wire

// ===== scp_pkg.sv
`default_nettype none
package scp_pkg;
  // register addresses of the serial map
  localparam logic [9:0] ADDR_PORT_CFG = 10'h000;
  localparam logic [9:0] ADDR_READBACK = 10'h004;
  localparam logic [9:0] ADDR_PLL_CTRL = 10'h010;
  localparam logic [9:0] ADDR_OUT0 = 10'h0f0;
  localparam logic [9:0] ADDR_OUT_LAST = 10'h0f5;
  localparam logic [9:0] ADDR_DIST = 10'h230;
  localparam logic [9:0] ADDR_UPDATE = 10'h232;
  localparam logic [9:0] ADDR_TOP = 10'h232;
  // bit positions
  localparam int BIT_SDO_EN = 0;
  localparam int BIT_LSB = 1;
  localparam int BIT_SRST_LO = 2;
  localparam int BIT_SRST_HI = 5;
  localparam int BIT_UPDATE = 0;
  localparam int BIT_RB_ACTIVE = 0;
  localparam int BIT_SOFT_SYNC = 0;
  localparam int BIT_DIST_PD = 1;
  localparam int OC_MODE_LO = 0;
  localparam int OC_SWING_LO = 2;
  localparam int OC_INV = 4;
  localparam int PLL_MODE_LO = 0;
  // reset values
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] BANK_RST = 8'h00;
  // buffered register bank layout
  localparam logic [3:0] NREG = 4'h9;
  localparam logic [3:0] IDX_RB = 4'h0;
  localparam logic [3:0] IDX_PLL = 4'h1;
  localparam logic [3:0] IDX_OUT0 = 4'h2;
  localparam logic [3:0] IDX_DIST = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hf;
  localparam int NOUT = 6;
  // mode encodings
  localparam logic [1:0] PLL_NORMAL = 2'h0;
  localparam logic [1:0] PLL_ASYNC_PD = 2'h1;
  localparam logic [1:0] PLL_SYNC_PD = 2'h3;
  localparam logic [1:0] OPD_NORMAL = 2'h0;
  localparam logic [1:0] OPD_SAFE = 2'h2;
  localparam logic [1:0] OPD_TOTAL = 2'h3;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;

  typedef logic [8:0][7:0] scp_regs_t;
  localparam scp_regs_t REG_DFLT = {9{BANK_RST}};
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_INSTR = 2'b01, ST_DATA = 2'b11, ST_STALL = 2'b10
  } scp_state_t;
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
  } scp_serial_t;
  typedef struct packed {
    logic pll_pd;
    logic vco_pd;
    logic clkin_pd;
    logic div_pd;
    logic dist_pd;
  } scp_pwr_t;
  typedef struct packed {
    logic invert;
    logic [1:0] swing;
    logic [1:0] pd_mode;
  } scp_outcfg_t;
endpackage
`default_nettype wire

// ===== scp_power_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module scp_power_ctl (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire scp_pkg::scp_regs_t act_i,
  input wire logic sleep_request_n_i,
  input wire logic cp_event_i,
  output scp_pkg::scp_pwr_t pwr_o,
  output scp_pkg::scp_outcfg_t [5:0] out_cfg_o
);
  import scp_pkg::*;
  typedef struct packed {
    logic pll_off;
    scp_pwr_t pwr;
    scp_outcfg_t [5:0] outs;
  } scp_pctl_t;
  scp_pctl_t r_ff, nxt_r;
  logic [1:0] pll_mode;
  logic asleep;

  assign pll_mode = act_i[IDX_PLL][PLL_MODE_LO +: 2];
  assign asleep = !sleep_request_n_i;

  // pll mode, pin sleep and per-output modes
  always_comb begin
    nxt_r = r_ff;
    case (pll_mode)
      PLL_ASYNC_PD: nxt_r.pll_off = 1'b1;
      PLL_SYNC_PD: nxt_r.pll_off = r_ff.pll_off | cp_event_i;
      default: nxt_r.pll_off = 1'b0;
    endcase
    nxt_r.pwr.pll_pd = asleep | nxt_r.pll_off;
    nxt_r.pwr.vco_pd = asleep;
    nxt_r.pwr.clkin_pd = asleep;
    nxt_r.pwr.div_pd = asleep;
    nxt_r.pwr.dist_pd = act_i[IDX_DIST][BIT_DIST_PD];
    for (int i = 0; i < NOUT; i++) begin
      nxt_r.outs[i].invert = act_i[IDX_OUT0 + 4'(i)][OC_INV];
      nxt_r.outs[i].swing = act_i[IDX_OUT0 + 4'(i)][OC_SWING_LO +: 2];
      // pin sleep forces safe off, else the mode stands
      nxt_r.outs[i].pd_mode = asleep ? OPD_SAFE
        : act_i[IDX_OUT0 + 4'(i)][OC_MODE_LO +: 2];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pwr_o = r_ff.pwr;
  assign out_cfg_o = r_ff.outs;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_pin_sleep_off: assert property (
    asleep |=> pwr_o.pll_pd && pwr_o.vco_pd && pwr_o.clkin_pd && pwr_o.div_pd
      && out_cfg_o[0].pd_mode == OPD_SAFE)
    else $error("pin sleep did not power down");
  a_pll_async_pd: assert property (
    pll_mode == PLL_ASYNC_PD |=> pwr_o.pll_pd)
    else $error("async pll power-down late");
  a_pll_sync_wait: assert property (
    pll_mode == PLL_SYNC_PD && !r_ff.pll_off && !cp_event_i && !asleep
      |=> !pwr_o.pll_pd)
    else $error("sync pll power-down before charge pump event");
  a_wake_resume: assert property (
    $rose(sleep_request_n_i) |=> !pwr_o.vco_pd
      && out_cfg_o[1].pd_mode == $past(act_i[IDX_OUT0 + 4'h1][OC_MODE_LO +: 2]))
    else $error("wake did not resume register settings");
  c_sync_pd: cover property (pll_mode == PLL_SYNC_PD && cp_event_i ##1 pwr_o.pll_pd);
endmodule
`default_nettype wire

// ===== scp_reg_bank.sv
`timescale 1ns/100ps
`default_nettype none
module scp_reg_bank (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic update_i,
  input wire logic soft_rst_i,
  output scp_pkg::scp_regs_t buf_o,
  output scp_pkg::scp_regs_t act_o
);
  import scp_pkg::*;
  typedef struct packed {
    scp_regs_t bufr;
    scp_regs_t actv;
  } scp_bank_t;
  scp_bank_t r_ff, nxt_r;

  // buffer write, simultaneous copy, soft default load
  always_comb begin
    nxt_r = r_ff;
    if (wr_i && wr_idx_i < NREG) begin
      nxt_r.bufr[wr_idx_i] = wr_data_i;
    end
    if (update_i) begin
      nxt_r.actv = r_ff.bufr;
    end
    if (soft_rst_i) begin
      nxt_r.bufr = REG_DFLT;
      nxt_r.actv = REG_DFLT;
    end
  end

  // defaults loaded and active from power-up or reset pin
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_ff <= {REG_DFLT, REG_DFLT};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign buf_o = r_ff.bufr;
  assign act_o = r_ff.actv;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_update_copy: assert property (
    update_i && !soft_rst_i |=> act_o == $past(buf_o))
    else $error("update did not copy buffer");
  a_soft_defaults: assert property (
    soft_rst_i |=> act_o == REG_DFLT && buf_o == REG_DFLT)
    else $error("soft reset did not restore defaults");
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import scp_pkg::*;
  typedef struct packed {
    logic [2:0] idx;
    logic [7:0] val;
  } scp_row_t;
  localparam int LIMIT = 40000;
  logic mclk_i;
  logic nrst_i;
  logic pin_rst_n;
  logic sleep_n;
  logic cp_ev;
  logic sdio;
  logic sdio_oe;
  logic serial_readback_out_pin;
  logic sdo_oe;
  logic sync;
  logic [2:0] cs_q = 3'b000;
  logic [7:0] d;
  logic [4:0] em [6] = '{default: 5'h00};
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  scp_serial_t ser;
  scp_pwr_t pwr;
  scp_outcfg_t [5:0] oc;
  // output index and value written
  scp_row_t rows [6] = '{'{3'd0, 8'h13}, '{3'd1, 8'h0e}, '{3'd2, 8'h14},
    '{3'd3, 8'h0b}, '{3'd4, 8'h1a}, '{3'd5, 8'h07}};

  scp_config_port DUT (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .reset_pin_n_i(pin_rst_n),
    .serial_i(ser),
    .sleep_request_n_i(sleep_n),
    .cp_event_i(cp_ev),
    .sdio_o(sdio),
    .sdio_oe_o(sdio_oe),
    .serial_readback_out_pin_o(serial_readback_out_pin),
    .serial_readback_out_pin_oe_o(sdo_oe),
    .sync_o(sync),
    .pwr_o(pwr),
    .out_cfg_o(oc)
  );
  scp_host_model h (
    .mclk_i(mclk_i),
    .sdio_i(sdio),
    .sdio_oe_i(sdio_oe),
    .sdo_i(serial_readback_out_pin),
    .sdo_oe_i(sdo_oe),
    .ser_o(ser)
  );

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic setreg(input logic [9:0] a, input logic [7:0] v);
    h.wr(a, v);
    h.upd();
  endtask

  // ceiling on cycles, floating and unused data pins
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    cs_q <= {cs_q[1:0], ser.cs_n};
    if (&cs_q && (sdio_oe !== 1'b0 || sdo_oe !== 1'b0)) begin
      fail_count++;
      $display("unexpected pin drive: expected 0, seen %b%b", sdio_oe, sdo_oe);
    end
    if ((h.uni ? sdio_oe : sdo_oe) !== 1'b0) begin
      fail_count++;
      $display("unexpected unused pin: expected 0, seen 1");
    end
    if (cyc == LIMIT) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    nrst_i = 1'b0;
    pin_rst_n = 1'b1;
    sleep_n = 1'b1;
    cp_ev = 1'b0;
    repeat (2) @(posedge mclk_i);
    #10 nrst_i = 1'b1;
    h.tick(1);
    chk("boot sync", 1, 32'(sync));
    h.tick(1);
    chk("boot sync end", 0, 32'(sync));
    chk("boot power", 0, 32'(pwr));
    chk("boot outputs", 0, 32'(oc));
    h.rd(ADDR_PORT_CFG, d);
    chk("port cfg", 'h18, 32'(d));
    // ordinary cases: buffered until update
    foreach (rows[i]) begin
      h.wr(ADDR_OUT0 + 10'(rows[i].idx), rows[i].val);
      chk("held", 32'(em[rows[i].idx]), 32'(oc[rows[i].idx]));
      h.rd(ADDR_OUT0 + 10'(rows[i].idx), d);
      chk("buffer", 32'(rows[i].val), 32'(d));
      h.upd();
      em[rows[i].idx] = rows[i].val[4:0];
      chk("out cfg", 32'(em[rows[i].idx]), 32'(oc[rows[i].idx]));
    end
    // readback from the active bank while the buffer differs
    setreg(ADDR_READBACK, 8'h01);
    h.wr(ADDR_OUT0 + 10'h5, 8'h1f);
    h.rd(ADDR_OUT0 + 10'h5, d);
    chk("active readback", 'h07, 32'(d));
    setreg(ADDR_READBACK, 8'h00);
    // three bytes, stalled after the first, address descending
    h.cs_dn();
    h.instr(1'b0, 2'b10, ADDR_OUT0 + 10'h2);
    h.put(8'h0e);
    h.cs_up();
    h.cs_dn();
    h.put(8'h07);
    h.put(8'h10);
    h.cs_up();
    h.upd();
    chk("stalled write", 'h38f0, 32'(oc[2:0]));
    // select rising mid-byte drops it; next transfer starts clean
    h.cs_dn();
    h.instr(1'b0, 2'b00, ADDR_OUT0);
    h.shift(8'h1f, 5);
    h.cs_up();
    setreg(ADDR_OUT0 + 10'h3, 8'h15);
    chk("abandoned", 'h10, 32'(oc[0]));
    chk("fresh", 'h15, 32'(oc[3]));
    // stall after the instruction, then abort with three clocks
    h.cs_dn();
    h.instr(1'b0, 2'b10, ADDR_OUT0 + 10'h4);
    h.cs_up();
    h.cs_dn();
    h.shift(8'h1f, 3);
    h.cs_up();
    h.upd();
    chk("aborted", 'h1a, 32'(oc[4]));
    // two-byte read on the separate pin
    h.wr(ADDR_PORT_CFG, 8'h99);
    h.uni = 1'b1;
    h.cs_dn();
    h.instr(1'b1, 2'b01, ADDR_OUT0 + 10'h1);
    h.get(d);
    chk("sdo byte 1", 'h07, 32'(d));
    h.get(d);
    chk("sdo byte 2", 'h10, 32'(d));
    h.cs_up();
    h.wr(ADDR_PORT_CFG, 8'h18);
    h.uni = 1'b0;
    // lsb-first stream climbing to the top, ending in update
    h.wr(ADDR_PORT_CFG, 8'h5a);
    h.lsb = 1'b1;
    h.cs_dn();
    h.instr(1'b0, LEN_STREAM, ADDR_DIST);
    h.put(8'h02);
    h.put(8'h00);
    h.put(8'h01);
    h.cs_up();
    chk("dist power", 1, 32'(pwr.dist_pd));
    h.wr(ADDR_PORT_CFG, 8'h18);
    h.lsb = 1'b0;
    // soft reset acts without update and ends on clearing
    h.wr(ADDR_PORT_CFG, 8'h3c);
    chk("soft sync", 1, 32'(sync));
    chk("soft outputs", 0, 32'(oc));
    chk("soft power", 0, 32'(pwr));
    h.wr(ADDR_PORT_CFG, 8'h18);
    chk("soft sync end", 0, 32'(sync));
    h.rd(ADDR_OUT0 + 10'h3, d);
    chk("soft buffer", 0, 32'(d));
    // sleep pin: blocks off, port alive, settings kept
    setreg(ADDR_OUT0, 8'h13);
    sleep_n = 1'b0;
    h.tick(2);
    chk("sleep power", 'h1e, 32'(pwr));
    chk("sleep out0", 'h12, 32'(oc[0]));
    setreg(ADDR_OUT0 + 10'h1, 8'h0c);
    chk("sleep out1", 'h0e, 32'(oc[1]));
    sleep_n = 1'b1;
    h.tick(2);
    chk("wake out0", 'h13, 32'(oc[0]));
    chk("wake out1", 'h0c, 32'(oc[1]));
    chk("wake power", 0, 32'(pwr));
    // host realigns outputs through the soft sync bit
    setreg(ADDR_DIST, 8'h01);
    chk("resync", 1, 32'(sync));
    setreg(ADDR_DIST, 8'h00);
    chk("resync end", 0, 32'(sync));
    // pll modes: at once, or on the charge pump event
    setreg(ADDR_PLL_CTRL, 8'(PLL_ASYNC_PD));
    chk("async pll", 1, 32'(pwr.pll_pd));
    setreg(ADDR_PLL_CTRL, 8'(PLL_NORMAL));
    setreg(ADDR_PLL_CTRL, 8'(PLL_SYNC_PD));
    chk("sync pll wait", 0, 32'(pwr.pll_pd));
    cp_ev = 1'b1;
    h.tick(1);
    cp_ev = 1'b0;
    h.tick(1);
    chk("sync pll", 1, 32'(pwr.pll_pd));
    // reset pin clears without a clock edge
    h.wr(ADDR_PORT_CFG, 8'h99);
    pin_rst_n = 1'b0;
    #20;
    chk("pin reset", 0, 32'(oc));
    h.tick(1);
    pin_rst_n = 1'b1;
    h.tick(1);
    chk("pin reset sync", 1, 32'(sync));
    h.tick(1);
    chk("pin reset power", 0, 32'(pwr));
    h.rd(ADDR_PORT_CFG, d);
    chk("pin reset cfg", 'h18, 32'(d));
    end_sim();
  end
endmodule
`default_nettype wire
